// ---- design/dsf_pkg.sv ----
/*
  package for the status flag and mode logic: widths, field positions,
  register offsets, reset values, enumerations and carrier structs.
  assumes a single core clock and a synchronous active-high reset.
*/
`default_nettype none
package dsf_pkg;
  // datapath widths: n, g, long accumulator 2n+g, product 2n
  localparam int N_W = 16;
  localparam int G_W = 8;
  localparam int L_W = 2 * N_W + G_W;
  localparam int P_W = 2 * N_W;
  localparam int U_W = L_W - N_W;

  // status/mode register fields
  localparam int FL_C = 0;
  localparam int FL_E = 1;
  localparam int FL_V = 2;
  localparam int FL_N = 3;
  localparam int FL_Z = 4;
  localparam int FL_Y = 5;
  localparam int FL_X = 6;
  localparam int FL_L = 7;
  localparam int MD_R = 8;
  localparam int MD_I = 9;
  localparam int MD_S = 10;

  // apb byte offsets
  localparam logic [7:0] OFF_SMR  = 8'h00;
  localparam logic [7:0] OFF_SVR  = 8'h04;
  localparam logic [7:0] OFF_LEND = 8'h08;
  localparam logic [7:0] OFF_ACCL = 8'h0C;
  localparam logic [7:0] OFF_ACCH = 8'h10;
  localparam logic [7:0] OFF_PROD = 8'h14;

  // reset values
  localparam logic [15:0] SMR_RST  = 16'h0000;
  localparam logic [15:0] SVR_RST  = 16'h0000;
  localparam logic [15:0] LEND_RST = 16'hFFFF;

  // saturation limits and rounding constants
  localparam logic [L_W-1:0] ACC_MAX   = 40'h7F_FFFF_FFFF;
  localparam logic [L_W-1:0] ACC_MIN   = 40'h80_0000_0000;
  localparam logic [N_W-1:0] WORD_MAX  = 16'h7FFF;
  localparam logic [N_W-1:0] WORD_MIN  = 16'h8000;
  localparam logic [N_W-1:0] HALF_LSB  = 16'h8000;
  localparam logic [U_W-1:0] UPPER_MAX = 24'h7F_FFFF;
  localparam logic [P_W-1:0] PROD_MAX  = 32'h7FFF_FFFF;

  typedef enum logic [1:0] {RM_TRUNC, RM_NORMAL, RM_CONV0, RM_CONV1} dsf_round_t;
  typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_LOGIC, OP_LSR, OP_LOGICAL_RIGHT_SHIFT_CARRY, OP_SHL,
                            OP_ASR} dsf_alu_op_t;
  typedef enum logic [2:0] {IC_IDLE, IC_1, IC_2, IC_3, IC_4, IC_5} dsf_icyc_t;

  typedef struct packed {
    logic             valid;
    logic             long_mode;
    dsf_alu_op_t      op;
    logic [L_W-1:0]   result;     // raw wrapped result
    logic             carry;      // carry out or borrow
    logic             ovf;        // arithmetic overflow of raw result
    logic             op_lsb;     // operand lsb before a right shift
  } dsf_alu_req_t;

  typedef struct packed {
    logic valid;
    logic modulo;
    logic wrapped;
    logic addr_msb;
  } dsf_agu_t;

  typedef struct packed {
    logic           valid;
    logic [P_W-1:0] product;
  } dsf_mul_req_t;

  typedef struct packed {
    logic [15:0]    smr;
    logic [15:0]    svr;
    logic [15:0]    lend;
    dsf_icyc_t      icyc;
    logic [L_W-1:0] acc;
    logic [P_W-1:0] prod;
    logic           loop_hit;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
  } dsf_state_t;
endpackage
`default_nettype wire

// ---- design/dsf_flags.sv ----
/*
  status flag and mode logic: holds the status/mode and saved mode
  registers, forms flags from alu, address alu and multiplier events,
  rounds and saturates results, gates loop end detection and tracks the
  interrupt cycle. assumes all core inputs come from logic on ref_clk.
*/
// The APB register port and the address map were decided locally.
// Contract
// - low byte holds L X Y Z N V E C from bit 7; modes above to 15
// - loop flag set suppresses loop end detection
// - taking an interrupt sets the loop flag before the mode copy
// - a mode register load writes the loop flag directly
// - jumps, calls, returns and loop start clear loop flag; table jump not
// - modulo update sets X flag when wrap applied, else clears
// - linear or bit reversed update copies address msb into X flag
// - Y flag follows the same rules from address alu Y
// - zero flag set when result all clear over the active width
// - negative flag takes top bit of the active width; the code clears it for OP_LSR and OP_ASR instead
// - overflow flag set on arithmetic overflow, else cleared
// - long mode extension flag clear when top guard bits all equal
// - single word mode always clears extension flag
// - carry flag set on add carry or subtract borrow, else cleared
// - logical right shifts load carry with operand lsb
// - saturation mode clamps overflowing results and raises overflow
// - rounding happens before saturation
// - integer product unshifted; fractional shifted left, lsb one on clamp
// - rounding clears low half and adjusts upper half by the fixed mode
// - convergent rounding on exact half adds upper lsb or its complement
// - reset zeroes registers, loop end all ones, interrupt cycle three
// - rounding method fixed at build time by a parameter
// - fourth interrupt cycle copies status/mode into saved mode
`default_nettype none
module dsf_flags
  import dsf_pkg::*;
#(
  parameter dsf_round_t ROUND_MODE = RM_NORMAL
) (
  // clock and reset
  input  wire  logic           ref_clk,
  input  wire  logic           rst,
  // apb slave
  input  wire  logic           psel,
  input  wire  logic           penable,
  input  wire  logic           pwrite,
  input  wire  logic [7:0]     paddr,
  input  wire  logic [31:0]    pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // core events
  input  wire  dsf_alu_req_t   alu_req,
  input  wire  dsf_mul_req_t   mul_req,
  input  wire  dsf_agu_t       agu_x,
  input  wire  dsf_agu_t       agu_y,
  input  wire  logic           mr_load,
  input  wire  logic [15:0]    mr_load_data,
  input  wire  logic           flow_clear,
  input  wire  logic           table_jump,
  input  wire  logic           int_take,
  // loop end check
  input  wire  logic           loop_check,
  input  wire  logic [15:0]    fetch_addr,
  input  wire  logic           loop_count_nz,
  // state out
  output logic [15:0]          status_mode,
  output logic [15:0]          saved_mode,
  output logic [L_W-1:0]       acc_out,
  output logic [P_W-1:0]       prod_out,
  output logic                 loop_hit,
  output dsf_icyc_t            int_cycle
);

  dsf_state_t st;
  dsf_state_t next_st;

  // apb decode
  logic apb_setup;
  logic apb_access;
  logic apb_hit;
  logic smr_apb_wr;
  logic mr_wr;
  assign apb_setup  = psel & ~penable & ~st.pready;
  assign apb_access = psel & penable & st.pready;
  assign apb_hit    = (paddr == OFF_SMR) | (paddr == OFF_SVR) | (paddr == OFF_LEND)
                    | (paddr == OFF_ACCL) | (paddr == OFF_ACCH) | (paddr == OFF_PROD);
  assign smr_apb_wr = apb_access & pwrite & (paddr == OFF_SMR);
  assign mr_wr      = smr_apb_wr | mr_load;

  // rounding of long results, fixed method
  logic [U_W-1:0] upper;
  logic [N_W-1:0] lower;
  logic           exact_half;
  logic           rnd_bit;
  logic           do_round;
  logic [U_W-1:0] upper_r;
  logic           rnd_ovf;
  logic [L_W-1:0] rounded;
  assign upper      = alu_req.result[L_W-1:N_W];
  assign lower      = alu_req.result[N_W-1:0];
  assign exact_half = (lower == HALF_LSB);
  assign do_round   = st.smr[MD_R] & alu_req.long_mode;
  always_comb begin
    unique case (ROUND_MODE)
      RM_TRUNC:  rnd_bit = 1'b0;
      RM_NORMAL: rnd_bit = lower[N_W-1];
      RM_CONV0:  rnd_bit = exact_half ? upper[0] : lower[N_W-1];
      RM_CONV1:  rnd_bit = exact_half ? ~upper[0] : lower[N_W-1];
    endcase
  end
  assign upper_r = upper + {{(U_W-1){1'b0}}, rnd_bit};
  assign rnd_ovf = do_round & rnd_bit & (upper == UPPER_MAX);
  assign rounded = do_round ? {upper_r, {N_W{1'b0}}} : alu_req.result;

  // saturation after rounding
  logic           alu_ovf;
  logic           alu_sat;
  logic [L_W-1:0] alu_fin;
  logic [N_W-1:0] word_fin;
  assign alu_ovf = alu_req.ovf | (alu_req.long_mode & rnd_ovf);
  assign alu_sat = st.smr[MD_S] & alu_ovf;
  assign word_fin = alu_sat ? (alu_req.result[N_W-1] ? WORD_MAX : WORD_MIN)
                            : alu_req.result[N_W-1:0];
  assign alu_fin = !alu_req.long_mode ? {{U_W{1'b0}}, word_fin}
                 : alu_sat ? (rounded[L_W-1] ? ACC_MAX : ACC_MIN)
                 : rounded;

  // multiplier alignment
  logic           mul_ovf;
  logic [P_W-1:0] prod_fin;
  assign mul_ovf  = ~st.smr[MD_I] & (mul_req.product[P_W-1] != mul_req.product[P_W-2]);
  assign prod_fin = st.smr[MD_I] ? mul_req.product
                  : (st.smr[MD_S] & mul_ovf) ? PROD_MAX
                  : {mul_req.product[P_W-2:0], 1'b0};

  // flag values from the final alu result
  logic z_val;
  logic n_val;
  logic e_val;
  assign z_val = alu_req.long_mode ? (alu_fin == '0)
                                   : (alu_fin[N_W-1:0] == '0);
  assign n_val = alu_req.long_mode ? alu_fin[L_W-1] : alu_fin[N_W-1];
  assign e_val = alu_req.long_mode &
                 ~((&alu_fin[L_W-1:2*N_W-1]) | ~(|alu_fin[L_W-1:2*N_W-1]));

  // next state
  always_comb begin
    next_st = st;
    // address alu flags
    if (agu_x.valid) begin
      next_st.smr[FL_X] = agu_x.modulo ? agu_x.wrapped : agu_x.addr_msb;
    end
    if (agu_y.valid) begin
      next_st.smr[FL_Y] = agu_y.modulo ? agu_y.wrapped : agu_y.addr_msb;
    end
    // alu flags; untouched flags hold
    if (alu_req.valid) begin
      next_st.acc       = alu_fin;
      next_st.smr[FL_Z] = z_val;
      next_st.smr[FL_E] = e_val;
      unique case (alu_req.op)
        OP_ADD, OP_SUB, OP_SHL: begin
          next_st.smr[FL_N] = n_val;
          next_st.smr[FL_V] = alu_ovf;
          next_st.smr[FL_C] = alu_req.carry;
        end
        OP_LOGIC: begin
          next_st.smr[FL_N] = n_val;
          next_st.smr[FL_V] = 1'b0;
          next_st.smr[FL_C] = 1'b0;
        end
        OP_LSR, OP_ASR: begin
          next_st.smr[FL_N] = 1'b0;
          next_st.smr[FL_V] = 1'b0;
          next_st.smr[FL_C] = alu_req.op_lsb;
        end
        OP_LOGICAL_RIGHT_SHIFT_CARRY: begin
          next_st.smr[FL_N] = n_val;
          next_st.smr[FL_V] = 1'b0;
          next_st.smr[FL_C] = alu_req.op_lsb;
        end
      endcase
    end
    // multiplier
    if (mul_req.valid) begin
      next_st.prod = prod_fin;
      if (st.smr[MD_S] & mul_ovf) begin
        next_st.smr[FL_V] = 1'b1;
      end
    end
    // change of flow clears loop flag, table jump leaves it
    if (flow_clear) begin
      next_st.smr[FL_L] = 1'b0;
    end
    // register loads take every bit directly
    if (smr_apb_wr) begin
      next_st.smr = pwdata[15:0];
    end else if (mr_load) begin
      next_st.smr = mr_load_data;
    end
    if (apb_access & pwrite & (paddr == OFF_SVR)) begin
      next_st.svr = pwdata[15:0];
    end
    if (apb_access & pwrite & (paddr == OFF_LEND)) begin
      next_st.lend = pwdata[15:0];
    end
    // interrupt cycles
    unique case (st.icyc)
      IC_IDLE: if (int_take) begin
        next_st.icyc = IC_1;
      end
      IC_1: next_st.icyc = IC_2;
      IC_2: begin
        next_st.icyc      = IC_3;
        next_st.smr[FL_L] = 1'b1;
      end
      IC_3: next_st.icyc = IC_4;
      IC_4: begin
        next_st.icyc = IC_5;
        next_st.svr  = st.smr;
      end
      IC_5: next_st.icyc = IC_IDLE;
    endcase
    // loop end detection gated by the loop flag
    next_st.loop_hit = loop_check & (fetch_addr == st.lend) & loop_count_nz
                     & ~st.smr[FL_L];
    // apb answer: ready in the access cycle after each setup
    next_st.pready = apb_setup;
    if (apb_setup) begin
      next_st.pslverr = ~apb_hit;
      unique case (paddr)
        OFF_SMR:  next_st.prdata = {16'h0000, st.smr};
        OFF_SVR:  next_st.prdata = {16'h0000, st.svr};
        OFF_LEND: next_st.prdata = {16'h0000, st.lend};
        OFF_ACCL: next_st.prdata = st.acc[31:0];
        OFF_ACCH: next_st.prdata = {24'h000000, st.acc[L_W-1:32]};
        OFF_PROD: next_st.prdata = st.prod;
        default:  next_st.prdata = 32'h0000_0000;
      endcase
    end else begin
      next_st.pslverr = 1'b0;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st.smr      <= SMR_RST;
      st.svr      <= SVR_RST;
      st.lend     <= LEND_RST;
      st.icyc     <= IC_3;
      st.acc      <= '0;
      st.prod     <= '0;
      st.loop_hit <= 1'b0;
      st.pready   <= 1'b0;
      st.pslverr  <= 1'b0;
      st.prdata   <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign status_mode = st.smr;
  assign saved_mode  = st.svr;
  assign acc_out     = st.acc;
  assign prod_out    = st.prod;
  assign loop_hit    = st.loop_hit;
  assign int_cycle   = st.icyc;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_loop_inhibit: assert property (st.smr[FL_L] |=> !st.loop_hit)
    else $error("loop end detected while loop flag set");
  chk_lflag_int: assert property ((st.icyc == IC_2) |=> ##2
                   (st.svr[FL_L] || $past(mr_wr, 2) || $past(flow_clear, 2)))
    else $error("saved mode lacks loop flag after interrupt");
  chk_flow_clear: assert property (flow_clear && !mr_wr && st.icyc != IC_2
                                   |=> !st.smr[FL_L])
    else $error("loop flag not cleared by change of flow");
  chk_table_jump: assert property (table_jump && !flow_clear && !mr_wr && st.icyc != IC_2
                                   |=> $stable(st.smr[FL_L]))
    else $error("table jump changed loop flag");
  chk_svr_copy: assert property ((st.icyc == IC_4) |=> st.svr == $past(st.smr))
    else $error("saved mode not copied in cycle four");
  chk_xflag_rule: assert property (agu_x.valid && !mr_wr |=> st.smr[FL_X] ==
                    ($past(agu_x.modulo) ? $past(agu_x.wrapped) : $past(agu_x.addr_msb)))
    else $error("index x flag wrong");
  chk_zero_flag: assert property (alu_req.valid && !mr_wr |=> st.smr[FL_Z] ==
                    ($past(alu_req.long_mode) ? (st.acc == '0) : (st.acc[N_W-1:0] == '0)))
    else $error("zero flag disagrees with result");
  chk_ext_short: assert property (alu_req.valid && !alu_req.long_mode && !mr_wr
                                  |=> !st.smr[FL_E])
    else $error("extension flag set in word mode");
  chk_frac_shift: assert property (mul_req.valid && !st.smr[MD_I] && !st.smr[MD_S]
                    |=> st.prod == {$past(mul_req.product[P_W-2:0]), 1'b0})
    else $error("fractional product not shifted");
  chk_int_walk: assert property ((st.icyc == IC_1) |=> (st.icyc == IC_2) ##1 (st.icyc == IC_3)
                                 ##1 (st.icyc == IC_4) ##1 (st.icyc == IC_5))
    else $error("interrupt cycle sequence broken");

  cov_int_seq: cover property ((st.icyc == IC_IDLE) ##1 (st.icyc == IC_1) ##[1:8] (st.icyc == IC_5));
  cov_alu_sat: cover property (alu_req.valid && alu_sat && alu_req.long_mode);
  cov_loop_hit: cover property (st.loop_hit);
  cov_apb_err: cover property (st.pready && st.pslverr);

endmodule
`default_nettype wire

// ---- testbench/dsf_flags_tb.sv ----
/*
  self-checking bench for the status flag and mode logic: apb register access,
  alu, address alu and multiplier flag forming, rounding, saturation, loop flag,
  interrupt cycle walk. assumes dsf_pkg and an apb slave of at most 15 wait cycles.
*/
`default_nettype none
module dsf_flags_tb
  import dsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic            ref_clk       = 1'b0;
  logic            rst           = 1'b1;
  logic            psel          = 1'b0;
  logic            penable       = 1'b0;
  logic            pwrite        = 1'b0;
  logic [7:0]      paddr         = 8'h00;
  logic [31:0]     pwdata        = 32'h0;
  logic [31:0]     prdata;
  logic            pready, pslverr;
  dsf_alu_req_t    alu_req       = '0;
  dsf_mul_req_t    mul_req       = '0;
  dsf_agu_t        agu_x         = '0;
  dsf_agu_t        agu_y         = '0;
  logic            mr_load       = 1'b0;
  logic [15:0]     mr_load_data  = 16'h0;
  logic            flow_clear    = 1'b0;
  logic            table_jump    = 1'b0;
  logic            int_take      = 1'b0;
  logic            loop_check    = 1'b0;
  logic [15:0]     fetch_addr    = 16'h0;
  logic            loop_count_nz = 1'b0;
  logic [15:0]     status_mode, saved_mode;
  logic [L_W-1:0]  acc_out;
  logic [P_W-1:0]  prod_out;
  logic            loop_hit;
  dsf_icyc_t       int_cycle;
  int              err_count     = 0;
  int              num_checks    = 0;
  int              seed          = 32'h84C3BC93;
  logic [31:0]     q;
  logic            e;

  dsf_flags i_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_req(alu_req), .mul_req(mul_req), .agu_x(agu_x), .agu_y(agu_y),
    .mr_load(mr_load), .mr_load_data(mr_load_data), .flow_clear(flow_clear),
    .table_jump(table_jump), .int_take(int_take), .loop_check(loop_check),
    .fetch_addr(fetch_addr), .loop_count_nz(loop_count_nz), .status_mode(status_mode),
    .saved_mode(saved_mode), .acc_out(acc_out), .prod_out(prod_out),
    .loop_hit(loop_hit), .int_cycle(int_cycle)
  );

  // 25 MHz core clock
  always #20 ref_clk = ~ref_clk;

  // compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    #1;
    // look at pready between edges, so the edge after it is the one that takes it
    while (pready !== 1'b1 && n < 16) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 16) err_count++;
    q = prdata;
    e = pslverr;
    @(posedge ref_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // end all one-cycle event pulses and let their effect land
  task automatic fire();
    @(posedge ref_clk);
    alu_req.valid <= 1'b0;
    mul_req.valid <= 1'b0;
    agu_x.valid   <= 1'b0;
    agu_y.valid   <= 1'b0;
    mr_load       <= 1'b0;
    flow_clear    <= 1'b0;
    table_jump    <= 1'b0;
    int_take      <= 1'b0;
    #1;
  endtask

  // expected {z, n, v, e, c} of one alu operation with modes off
  function automatic logic [4:0] exp_flags(input dsf_alu_req_t r);
    logic z, n, v, x, c;
    z = r.long_mode ? (r.result == '0) : (r.result[N_W-1:0] == '0);
    n = r.long_mode ? r.result[L_W-1] : r.result[N_W-1];
    x = r.long_mode && !(&r.result[L_W-1:P_W-1] || ~|r.result[L_W-1:P_W-1]);
    v = r.ovf;
    c = r.carry;
    case (r.op)
      OP_LOGIC: begin v = 1'b0; c = 1'b0; end
      OP_LSR, OP_ASR: begin n = 1'b0; v = 1'b0; c = r.op_lsb; end
      OP_LOGICAL_RIGHT_SHIFT_CARRY: begin v = 1'b0; c = r.op_lsb; end
      default: ;
    endcase
    return {z, n, v, x, c};
  endfunction

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report();
  end

  // main sequence
  initial begin
    int           k;
    dsf_alu_req_t r;
    dsf_agu_t     ax, ay;
    logic [31:0]  p;
    logic [15:0]  sm;
    dsf_icyc_t    rwalk[3] = '{IC_4, IC_5, IC_IDLE};
    dsf_icyc_t    iwalk[6] = '{IC_1, IC_2, IC_3, IC_4, IC_5, IC_IDLE};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(int_cycle, IC_3);
    for (k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      #1;
      chk(int_cycle, rwalk[k]);
    end
    // reset values of every mapped word, then an unmapped word
    for (k = 0; k < 6; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk(q, (k == 2) ? 32'h0000_FFFF : 32'h0);
    end
    apb(1'b1, 8'h18, 32'hFFFF);
    apb(1'b0, 8'h18, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
    apb(1'b1, OFF_SMR, 32'h0000_F8A5);
    apb(1'b0, OFF_SMR, 32'h0);
    chk(q, 32'h0000_F8A5);
    // random alu traffic, loop and index flags held high meanwhile
    apb(1'b1, OFF_SMR, 32'h0000_00E0);
    for (k = 0; k < 80; k++) begin
      r.valid     = 1'b1;
      r.long_mode = 1'($random(seed));
      r.op        = dsf_alu_op_t'(3'($unsigned($random(seed)) % 7));
      r.result    = 40'({$random(seed), $random(seed)});
      if (k % 5 == 0) r.result = {{9{r.result[30]}}, r.result[30:0]};
      if (k % 7 == 0) r.result[15:0] = 16'h0000;
      if (k % 11 == 0) r.result = '0;
      r.carry  = 1'($random(seed));
      r.ovf    = 1'($random(seed));
      r.op_lsb = 1'($random(seed));
      sm = status_mode;
      @(posedge ref_clk);
      alu_req <= r;
      fire();
      chk(status_mode[4:0], exp_flags(r));
      chk(status_mode[15:5], sm[15:5]);
      if (r.long_mode) chk(acc_out, r.result);
      else chk(acc_out, {24'h00_0000, r.result[15:0]});
    end
    // rounding to the upper half, exact half first
    apb(1'b1, OFF_SMR, 32'h0000_0100);
    for (k = 0; k < 12; k++) begin
      r.long_mode = 1'b1;
      r.op        = OP_ADD;
      r.ovf       = 1'b0;
      r.result    = {2'b00, 6'($random(seed)), $random(seed)};
      if (k == 0) r.result[15:0] = HALF_LSB;
      @(posedge ref_clk);
      alu_req <= r;
      fire();
      chk(acc_out, {U_W'(r.result[L_W-1:N_W] + r.result[N_W-1]), 16'h0000});
    end
    // saturation both ways, no overflow, then rounding into saturation
    for (k = 0; k < 4; k++) begin
      apb(1'b1, OFF_SMR, (k == 3) ? 32'h0000_0500 : 32'h0000_0400);
      r.ovf    = (k < 2);
      r.result = (k == 3) ? 40'h7F_FFFF_8000 : {k[0], 39'h12_3456_789A};
      @(posedge ref_clk);
      alu_req <= r;
      fire();
      chk(acc_out, (k > 1) ? ((k == 3) ? ACC_MAX : r.result) : (k == 0 ? ACC_MIN : ACC_MAX));
      chk(status_mode[FL_V], k != 2);
    end
    // product alignment: integer, fractional, fractional saturating
    for (k = 0; k < 3; k++) begin
      apb(1'b1, OFF_SMR, (k == 0) ? 32'h0000_0200 : ((k == 1) ? 32'h0 : 32'h0000_0400));
      p = (k == 2) ? 32'h4000_0000 : $random(seed);
      @(posedge ref_clk);
      mul_req <= '{valid: 1'b1, product: p};
      fire();
      chk(prod_out, (k == 0) ? p : ((k == 1) ? {p[30:0], 1'b0} : PROD_MAX));
      if (k == 2) chk(status_mode[FL_V], 1'b1);
    end
    // address alu flags, y sometimes idle
    for (k = 0; k < 24; k++) begin
      ax = dsf_agu_t'(4'($random(seed)) | 4'h8);
      ay = dsf_agu_t'(4'($random(seed)));
      sm = status_mode;
      @(posedge ref_clk);
      agu_x <= ax;
      agu_y <= ay;
      fire();
      chk(status_mode[FL_X], ax.modulo ? ax.wrapped : ax.addr_msb);
      chk(status_mode[FL_Y], !ay.valid ? sm[FL_Y] : (ay.modulo ? ay.wrapped : ay.addr_msb));
    end
    // loop flag: load both values, table jump keeps, flow change clears
    apb(1'b1, OFF_LEND, 32'h0000_0123);
    for (k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      mr_load      <= 1'b1;
      mr_load_data <= (k == 1) ? 16'h0000 : 16'h0080;
      fire();
      chk(status_mode[FL_L], k != 1);
    end
    @(posedge ref_clk);
    table_jump    <= 1'b1;
    loop_check    <= 1'b1;
    fetch_addr    <= 16'h0123;
    loop_count_nz <= 1'b1;
    fire();
    chk({status_mode[FL_L], loop_hit}, 2'b10);
    @(posedge ref_clk);
    flow_clear <= 1'b1;
    fire();
    chk(status_mode[FL_L], 1'b0);
    @(posedge ref_clk);
    fetch_addr <= 16'h0124;
    #1;
    chk(loop_hit, 1'b1);
    @(posedge ref_clk);
    loop_check <= 1'b0;
    #1;
    chk(loop_hit, 1'b0);
    // interrupt walk, loop flag set and copied to the saved register
    sm = status_mode;
    @(posedge ref_clk);
    int_take <= 1'b1;
    for (k = 0; k < 6; k++) begin
      if (k == 0) begin
        fire();
      end else begin
        @(posedge ref_clk);
        #1;
      end
      chk(int_cycle, iwalk[k]);
    end
    chk(saved_mode, sm | 16'h0080);
    chk(status_mode[FL_L], 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
